// ---- scr_host_model.sv ----
`timescale 1ns/1ps

// host controller on the four-wire serial configuration port
module scr_host_model (
    input wire logic clk,
    output logic sclk,
    output logic csN,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdoOe
);
    logic [7:0] wbuf [8];
    logic [7:0] rbuf [8];
    logic oeSeen;

    // idle: clock stands low outside frames, select high
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
        oeSeen = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one bit: each sclk phase lasts four clk cycles, four times the one-cycle minimum the port needs
    task automatic bit_xfer(input logic b, output logic s, output logic o);
        sdi = b;
        repeat (4) @(negedge clk);
        s = sdo; // read data arrives on its own output pin
        o = sdoOe;
        sclk = 1'b1;
        repeat (4) @(negedge clk);
        sclk = 1'b0;
    endtask

    // a whole frame: read flag, fifteen address bits, then n bytes, all msb first
    task automatic xfer(input logic rd, input logic [14:0] adr, input int n);
        logic [15:0] hdr;
        logic s;
        logic o;
        hdr = {rd, adr};
        oeSeen = 1'b1;
        csN = 1'b0;
        @(negedge clk);
        for (int i = 15; i >= 0; i--) bit_xfer(hdr[i], s, o);
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                // unused input during reads toggles so it never looks like stale data
                bit_xfer(rd ? ~sdi : wbuf[k][i], s, o);
                rbuf[k][i] = s;
                // the pin is driven in read data phases and released in write frames
                if (o !== rd) oeSeen = 1'b0;
            end
        end
        sdi = ~sdi;
        @(negedge clk);
        csN = 1'b1;
        repeat (2) @(negedge clk);
    endtask
endmodule

// ---- scr_params.svh ----
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH

// register byte offsets on the serial configuration port
`define SCR_OFF_CONFIG 15'h0000
`define SCR_OFF_CLASS 15'h0003
`define SCR_OFF_PART_LO 15'h0004
`define SCR_OFF_PART_HI 15'h0005
`define SCR_OFF_REV 15'h0006
`define SCR_OFF_MAKER_LO 15'h000C
`define SCR_OFF_MAKER_HI 15'h000D
`define SCR_OFF_USER 15'h0010
`define SCR_OFF_CLKA 15'h0029
`define SCR_OFF_CLKB 15'h002A
`define SCR_OFF_POS0 15'h002C
`define SCR_OFF_POS1 15'h002D
`define SCR_OFF_POS2 15'h002E
`define SCR_OFF_SCALEA_LO 15'h0030
`define SCR_OFF_SCALEA_HI 15'h0031
`define SCR_OFF_SCALEB_LO 15'h0032
`define SCR_OFF_SCALEB_HI 15'h0033
`define SCR_OFF_REFBYP 15'h0038
`define SCR_OFF_TSTAMP 15'h003B

// field positions
`define SCR_DIR_BIT 5
`define SCR_SDO_ACT_BIT 4
`define SCR_HOLD_BIT 0
`define SCR_PROC_EN_BIT 6
`define SCR_RECV_EN_BIT 5
`define SCR_ZOOM_BIT 4

// reset values, and the value read from reserved holes
`define SCR_DIR_RST 1'b1
`define SCR_USER_RST 8'h00
`define SCR_CLKA_RST 8'h00
`define SCR_CLKB_RST 8'h20
`define SCR_SCALE_RST 16'hA000
`define SCR_REFBYP_RST 8'h00
`define SCR_TSTAMP_RST 8'h00
`define SCR_RSVD_READ 8'h00

// frame layout: one direction bit, fifteen address bits, then bytes
`define SCR_HDR_LAST 5'd15
`define SCR_BYTE_LAST 5'd7

`endif

// ---- scr_pkg.sv ----
package scr_pkg;

    typedef enum logic [1:0] {
        SCR_IDLE = 2'b00,
        SCR_HEADER = 2'b01,
        SCR_DATA = 2'b10
    } scr_state_type;

    // writable configuration, also presented to the converter
    typedef struct packed {
        logic addrDir;
        logic [7:0] userCfg;
        logic [7:0] clkCtrlA;
        logic [7:0] clkCtrlB;
        logic [15:0] scaleA;
        logic [15:0] scaleB;
        logic [7:0] refBypass;
        logic [7:0] tstampCtrl;
    } scr_regs_type;

    // decoded alignment fields of clocking control a
    typedef struct packed {
        logic procEnable;
        logic recvEnable;
        logic zoom;
        logic [3:0] delaySelect;
    } scr_clk_fields_type;

endpackage

// ---- scr_register_bank.sv ----
`timescale 1ns/1ps
`include "scr_params.svh"

module scr_register_bank
    import scr_pkg::*;
#(
    parameter logic [3:0] CLASS_CODE = 4'h9,      // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h0C35,  // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h02,  // arbitrary value
    parameter logic [15:0] MAKER_CODE = 16'h5AA5  // arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdi,
    output logic sdo,
    output logic sdoOe,
    input wire logic [23:0] alignEdgePosition,
    output scr_regs_type cfgOut,
    output scr_clk_fields_type clkFields
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops

    logic [1:0] rstSync_reg;
    logic rstN;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_reg <= 2'b00;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end

    assign rstN = rstSync_reg[1];

    ////////////////////////////////////////////////////////////////////////////
    // read decode

    // reserved holes answer zero; their content is undefined to software
    function automatic logic [7:0] readByte(
        input logic [14:0] a,
        input scr_regs_type r,
        input logic [23:0] pos
    );
        logic [7:0] cfgByte;
        cfgByte = 8'h00;
        cfgByte[`SCR_DIR_BIT] = r.addrDir;
        cfgByte[`SCR_SDO_ACT_BIT] = 1'b1; // four-wire only
        case (a)
            `SCR_OFF_CONFIG: readByte = cfgByte;
            `SCR_OFF_CLASS: readByte = {4'h0, CLASS_CODE};
            `SCR_OFF_PART_LO: readByte = PART_CODE[7:0];
            `SCR_OFF_PART_HI: readByte = PART_CODE[15:8];
            `SCR_OFF_REV: readByte = REVISION_CODE;
            `SCR_OFF_MAKER_LO: readByte = MAKER_CODE[7:0];
            `SCR_OFF_MAKER_HI: readByte = MAKER_CODE[15:8];
            `SCR_OFF_USER: readByte = r.userCfg;
            `SCR_OFF_CLKA: readByte = r.clkCtrlA;
            `SCR_OFF_CLKB: readByte = r.clkCtrlB;
            `SCR_OFF_POS0: readByte = pos[7:0];
            `SCR_OFF_POS1: readByte = pos[15:8];
            `SCR_OFF_POS2: readByte = pos[23:16];
            `SCR_OFF_SCALEA_LO: readByte = r.scaleA[7:0];
            `SCR_OFF_SCALEA_HI: readByte = r.scaleA[15:8];
            `SCR_OFF_SCALEB_LO: readByte = r.scaleB[7:0];
            `SCR_OFF_SCALEB_HI: readByte = r.scaleB[15:8];
            `SCR_OFF_REFBYP: readByte = r.refBypass;
            `SCR_OFF_TSTAMP: readByte = r.tstampCtrl;
            default: readByte = `SCR_RSVD_READ;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // serial frame engine

    scr_state_type state_reg, state_next;
    logic [4:0] bitCnt_reg, bitCnt_next;
    logic [15:0] shiftIn_reg, shiftIn_next;
    logic [7:0] shiftOut_reg, shiftOut_next;
    logic [14:0] addr_reg, addr_next;
    logic rdMode_reg, rdMode_next;
    logic sdo_reg, sdo_next;
    logic sclkPrev_reg;
    scr_regs_type regs_reg, regs_next;

    logic sclkRise;
    logic sclkFall;
    logic [15:0] inWord;
    logic [14:0] stepAddr;
    logic loadEn;
    logic [14:0] loadAddr;
    logic wrEn;
    logic byteEnd;

    assign sclkRise = sclk & ~sclkPrev_reg;
    assign sclkFall = ~sclk & sclkPrev_reg;
    assign inWord = {shiftIn_reg[14:0], sdi};

    // address for the next byte of a stream
    always_comb begin
        if (regs_reg.userCfg[`SCR_HOLD_BIT]) begin
            stepAddr = addr_reg;
        end else if (regs_reg.addrDir) begin
            stepAddr = addr_reg + 15'h0001;
        end else begin
            stepAddr = addr_reg - 15'h0001;
        end
    end

    // bit and byte sequencing; data is sampled on the rising serial edge
    always_comb begin
        state_next = state_reg;
        bitCnt_next = bitCnt_reg;
        shiftIn_next = shiftIn_reg;
        addr_next = addr_reg;
        rdMode_next = rdMode_reg;
        loadEn = 1'b0;
        loadAddr = addr_reg;
        wrEn = 1'b0;
        byteEnd = 1'b0;
        if (csN) begin
            state_next = SCR_IDLE;
            bitCnt_next = 5'd0;
        end else begin
            case (state_reg)
                SCR_IDLE, SCR_HEADER: begin
                    state_next = SCR_HEADER;
                    if (sclkRise) begin
                        shiftIn_next = inWord;
                        bitCnt_next = bitCnt_reg + 5'd1;
                        if (bitCnt_reg == `SCR_HDR_LAST) begin
                            state_next = SCR_DATA;
                            bitCnt_next = 5'd0;
                            rdMode_next = inWord[15];
                            addr_next = inWord[14:0];
                            loadEn = 1'b1;
                            loadAddr = inWord[14:0];
                        end
                    end
                end
                SCR_DATA: begin
                    if (sclkRise) begin
                        shiftIn_next = inWord;
                        bitCnt_next = bitCnt_reg + 5'd1;
                        if (bitCnt_reg == `SCR_BYTE_LAST) begin
                            byteEnd = 1'b1;
                            bitCnt_next = 5'd0;
                            wrEn = ~rdMode_reg;
                            addr_next = stepAddr;
                            loadEn = rdMode_reg;
                            loadAddr = stepAddr;
                        end
                    end
                end
                default: begin
                    state_next = SCR_IDLE;
                    bitCnt_next = 5'd0;
                end
            endcase
        end
    end

    // read data leaves msb first, changing on the falling serial edge
    always_comb begin
        shiftOut_next = shiftOut_reg;
        sdo_next = sdo_reg;
        if (loadEn) begin
            shiftOut_next = readByte(loadAddr, regs_reg, alignEdgePosition);
        end else if (sclkFall) begin
            sdo_next = shiftOut_reg[7];
            shiftOut_next = {shiftOut_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_reg <= SCR_IDLE;
            bitCnt_reg <= 5'd0;
            shiftIn_reg <= 16'h0000;
            shiftOut_reg <= 8'h00;
            addr_reg <= 15'h0000;
            rdMode_reg <= 1'b0;
            sdo_reg <= 1'b0;
            sclkPrev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bitCnt_reg <= bitCnt_next;
            shiftIn_reg <= shiftIn_next;
            shiftOut_reg <= shiftOut_next;
            addr_reg <= addr_next;
            rdMode_reg <= rdMode_next;
            sdo_reg <= sdo_next;
            sclkPrev_reg <= sclk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    // identification, position and reserved addresses have no storage
    always_comb begin
        regs_next = regs_reg;
        if (wrEn) begin
            case (addr_reg)
                `SCR_OFF_CONFIG: regs_next.addrDir = inWord[`SCR_DIR_BIT];
                `SCR_OFF_USER: regs_next.userCfg = inWord[7:0];
                `SCR_OFF_CLKA: regs_next.clkCtrlA = inWord[7:0];
                `SCR_OFF_CLKB: regs_next.clkCtrlB = inWord[7:0];
                `SCR_OFF_SCALEA_LO: regs_next.scaleA[7:0] = inWord[7:0];
                `SCR_OFF_SCALEA_HI: regs_next.scaleA[15:8] = inWord[7:0];
                `SCR_OFF_SCALEB_LO: regs_next.scaleB[7:0] = inWord[7:0];
                `SCR_OFF_SCALEB_HI: regs_next.scaleB[15:8] = inWord[7:0];
                `SCR_OFF_REFBYP: regs_next.refBypass = inWord[7:0];
                `SCR_OFF_TSTAMP: regs_next.tstampCtrl = inWord[7:0];
                default: regs_next = regs_reg;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regs_reg.addrDir <= `SCR_DIR_RST;
            regs_reg.userCfg <= `SCR_USER_RST;
            regs_reg.clkCtrlA <= `SCR_CLKA_RST;
            regs_reg.clkCtrlB <= `SCR_CLKB_RST;
            regs_reg.scaleA <= `SCR_SCALE_RST;
            regs_reg.scaleB <= `SCR_SCALE_RST;
            regs_reg.refBypass <= `SCR_REFBYP_RST;
            regs_reg.tstampCtrl <= `SCR_TSTAMP_RST;
        end else begin
            regs_reg <= regs_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // pin stays driven only while a read stream is under way
    assign sdo = sdo_reg;
    assign sdoOe = (state_reg == SCR_DATA) & rdMode_reg & ~csN;
    assign cfgOut = regs_reg;
    assign clkFields.procEnable = regs_reg.clkCtrlA[`SCR_PROC_EN_BIT];
    assign clkFields.recvEnable = regs_reg.clkCtrlA[`SCR_RECV_EN_BIT];
    assign clkFields.zoom = regs_reg.clkCtrlA[`SCR_ZOOM_BIT];
    assign clkFields.delaySelect = regs_reg.clkCtrlA[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    class_upper_zero_a: assert property (
        loadEn && loadAddr == `SCR_OFF_CLASS |=> shiftOut_reg == {4'h0, CLASS_CODE})
        else $error("class byte loaded wrong");

    part_code_fixed_a: assert property (
        loadEn && loadAddr == `SCR_OFF_PART_HI |=> shiftOut_reg == PART_CODE[15:8])
        else $error("part code high byte wrong");

    revision_fixed_a: assert property (
        loadEn && loadAddr == `SCR_OFF_REV |=> shiftOut_reg == REVISION_CODE)
        else $error("revision byte wrong");

    maker_code_fixed_a: assert property (
        loadEn && loadAddr == `SCR_OFF_MAKER_LO |=> shiftOut_reg == MAKER_CODE[7:0])
        else $error("maker code low byte wrong");

    addr_ascend_a: assert property (
        byteEnd && !regs_reg.userCfg[0] && regs_reg.addrDir
        |=> addr_reg == $past(addr_reg) + 15'h0001)
        else $error("address did not ascend");

    addr_descend_a: assert property (
        byteEnd && !regs_reg.userCfg[0] && !regs_reg.addrDir
        |=> addr_reg == $past(addr_reg) - 15'h0001)
        else $error("address did not descend");

    addr_hold_a: assert property (
        byteEnd && regs_reg.userCfg[0] |=> $stable(addr_reg))
        else $error("frozen address moved");

    ro_write_drop_a: assert property (
        wrEn && addr_reg <= `SCR_OFF_MAKER_HI && addr_reg != `SCR_OFF_CONFIG
        |=> $stable(regs_reg))
        else $error("read-only write changed state");

    scale_write_a: assert property (
        wrEn && addr_reg == `SCR_OFF_SCALEA_HI
        |=> regs_reg.scaleA[15:8] == $past(inWord[7:0]))
        else $error("scale high byte not written");

    sdo_drive_a: assert property (
        state_reg == SCR_DATA && rdMode_reg && !csN && sclkFall && !loadEn
        |=> sdo == $past(shiftOut_reg[7]))
        else $error("read data pin not carrying the byte");

endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
`include "scr_params.svh"

module tb
    import scr_pkg::*;
();
    localparam logic [3:0] CLS = 4'h6;      // arbitrary value
    localparam logic [15:0] PRT = 16'h7E21; // arbitrary value
    localparam logic [7:0] REV = 8'h4C;     // arbitrary value
    localparam logic [15:0] MKR = 16'h3C96; // arbitrary value
    localparam scr_regs_type RST_CFG = {`SCR_DIR_RST, `SCR_USER_RST, `SCR_CLKA_RST,
        `SCR_CLKB_RST, `SCR_SCALE_RST, `SCR_SCALE_RST, `SCR_REFBYP_RST, `SCR_TSTAMP_RST};

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sclk, csN, sdi, sdo, sdoOe;
    logic [23:0] alignEdgePosition = 24'h123456;
    scr_regs_type cfgOut;
    scr_clk_fields_type clkFields;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [14:0] rsvd [14] = '{15'h0007, 15'h000E, 15'h0011, 15'h001F, 15'h0020, 15'h0028,
        15'h002B, 15'h002F, 15'h0034, 15'h0037, 15'h0039, 15'h003A, 15'h003C, 15'h0047};
    logic [14:0] rstAdr [10] = '{`SCR_OFF_USER, `SCR_OFF_CLKA, `SCR_OFF_CLKB,
        `SCR_OFF_SCALEA_LO, `SCR_OFF_SCALEA_HI, `SCR_OFF_SCALEB_LO, `SCR_OFF_SCALEB_HI,
        `SCR_OFF_REFBYP, `SCR_OFF_TSTAMP, `SCR_OFF_CONFIG};
    logic [7:0] rstVal [10] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'hA0, 8'h00, 8'hA0, 8'h00,
        8'h00, 8'h30};

    always #10 clk = ~clk;

    scr_register_bank #(.CLASS_CODE(CLS), .PART_CODE(PRT), .REVISION_CODE(REV),
        .MAKER_CODE(MKR)) dut (.clk(clk), .rst_n(rst_n), .sclk(sclk), .csN(csN), .sdi(sdi),
        .sdo(sdo), .sdoOe(sdoOe), .alignEdgePosition(alignEdgePosition), .cfgOut(cfgOut),
        .clkFields(clkFields));

    scr_host_model host (.clk(clk), .sclk(sclk), .csN(csN), .sdi(sdi), .sdo(sdo),
        .sdoOe(sdoOe));

    ////////////////////////////////////////////////////////////////////////////////
    // comparison, verdict and hang guard
    // wide enough for the whole configuration struct, so no field is cut off
    task automatic check(input string what, input logic [79:0] seen, input logic [79:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // the full sequence needs roughly 12000 cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            conclude();
        end
    end

    // single byte write and reset pulse, both launched on falling edges
    task automatic wr1(input logic [14:0] a, input logic [7:0] b);
        host.wbuf[0] = b;
        host.xfer(1'b0, a, 1);
    endtask

    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        do_reset();
        check("cfg after reset", cfgOut, RST_CFG);
        for (int i = 0; i < 10; i++) begin
            host.xfer(1'b1, rstAdr[i], 1);
            check("reset read", host.rbuf[0], rstVal[i]);
        end
        // identity and position writes must be dropped
        for (int k = 0; k < 4; k++) host.wbuf[k] = 8'hFF;
        host.xfer(1'b0, `SCR_OFF_CLASS, 4);
        host.xfer(1'b0, `SCR_OFF_MAKER_LO, 2);
        host.xfer(1'b0, `SCR_OFF_POS0, 3);
        host.xfer(1'b1, `SCR_OFF_CLASS, 4);
        check("class", host.rbuf[0], {4'h0, CLS});
        check("part", {host.rbuf[2], host.rbuf[1]}, PRT);
        check("revision", host.rbuf[3], REV);
        check("read enable", host.oeSeen, 1'b1);
        host.xfer(1'b1, `SCR_OFF_MAKER_LO, 2);
        check("maker", {host.rbuf[1], host.rbuf[0]}, MKR);
        host.xfer(1'b1, `SCR_OFF_POS0, 3);
        check("position", {host.rbuf[2], host.rbuf[1], host.rbuf[0]}, 24'h123456);
        // reserved holes keep nothing
        for (int i = 0; i < 14; i++) begin
            wr1(rsvd[i], 8'hFF);
            host.xfer(1'b1, rsvd[i], 1);
            check("reserved", host.rbuf[0], `SCR_RSVD_READ);
        end
        // ascending stream over both scale registers
        host.wbuf[0] = 8'h12;
        host.wbuf[1] = 8'h34;
        host.wbuf[2] = 8'h56;
        host.wbuf[3] = 8'h78;
        host.xfer(1'b0, `SCR_OFF_SCALEA_LO, 4);
        check("scale a", cfgOut.scaleA, 16'h3412);
        check("scale b", cfgOut.scaleB, 16'h7856);
        check("write pin quiet", host.oeSeen, 1'b1);
        // descending stream after clearing the direction bit
        wr1(`SCR_OFF_CONFIG, 8'h00);
        check("direction", cfgOut.addrDir, 1'b0);
        host.xfer(1'b1, `SCR_OFF_CONFIG, 1);
        check("config", host.rbuf[0], 8'h10);
        host.wbuf[0] = 8'hAB;
        host.wbuf[1] = 8'hCD;
        host.xfer(1'b0, `SCR_OFF_SCALEB_HI, 2);
        check("scale b down", cfgOut.scaleB, 16'hABCD);
        check("scale a kept", cfgOut.scaleA, 16'h3412);
        wr1(`SCR_OFF_CONFIG, 8'h20);
        // frozen address: three bytes land on one register
        wr1(`SCR_OFF_USER, 8'h01);
        check("user", cfgOut.userCfg, 8'h01);
        host.wbuf[0] = 8'h11;
        host.wbuf[1] = 8'h22;
        host.wbuf[2] = 8'h33;
        host.xfer(1'b0, `SCR_OFF_REFBYP, 3);
        host.xfer(1'b1, `SCR_OFF_REFBYP, 2);
        check("held read", {host.rbuf[1], host.rbuf[0]}, 16'h3333);
        check("bypass", cfgOut.refBypass, 8'h33);
        wr1(`SCR_OFF_USER, 8'h00);
        // alignment fields of clocking control a
        wr1(`SCR_OFF_CLKA, 8'h5A);
        check("clock fields", clkFields, 7'h5A);
        host.xfer(1'b1, `SCR_OFF_CLKA, 1);
        check("clock a", host.rbuf[0], 8'h5A);
        // a second reset restores every writable value
        do_reset();
        check("cfg after reset", cfgOut, RST_CFG);
        conclude();
    end
endmodule
